/* File: hdl/ecu_pkg.sv */
// constants and types shared by the eight-bit counter unit
package ecu_pkg;

  // ==========================================================
  // register map, byte addresses
  localparam int ECU_AW = 5;
  localparam logic [4:0] OFF_CTRL_A   = 5'h00;
  localparam logic [4:0] OFF_CTRL_B   = 5'h04;
  localparam logic [4:0] OFF_COUNT    = 5'h08;
  localparam logic [4:0] OFF_CMP_A    = 5'h0C;
  localparam logic [4:0] OFF_ASYNC    = 5'h10;
  localparam logic [4:0] OFF_INT_STAT = 5'h14;
  localparam logic [4:0] OFF_INT_MASK = 5'h18;

  // ==========================================================
  // field positions
  localparam int CTRL_B_WGM2_BIT = 3;
  localparam int ASYNC_SEL_BIT   = 0;
  localparam int INT_OVF_BIT     = 0;
  localparam int INT_CMPA_BIT    = 1;

  // ==========================================================
  // reference values and reset values
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL    = 8'hFF;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [7:0] CMP_RST    = 8'h00;
  localparam logic [1:0] CTRL_A_RST = 2'h0;
  localparam logic [3:0] CTRL_B_RST = 4'h0;
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [1:0] INT_RST    = 2'h0;

  // ==========================================================
  // waveform mode codes
  localparam logic [2:0] WGM_NORMAL   = 3'h0;
  localparam logic [2:0] WGM_PC_MAX   = 3'h1;
  localparam logic [2:0] WGM_CTC      = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_CMP   = 3'h5;
  localparam logic [2:0] WGM_FAST_CMP = 3'h7;

  // counting direction of the dual-slope modes
  typedef enum logic {ECU_UP, ECU_DOWN} ecu_dir_e;

  // highest value of the count sequence for a mode
  function automatic logic [7:0] ecu_top_of(input logic [2:0] mode,
                                            input logic [7:0] cmp);
    case (mode)
      WGM_CTC, WGM_PC_CMP, WGM_FAST_CMP: ecu_top_of = cmp;
      default:                           ecu_top_of = MAX_VAL;
    endcase
  endfunction

endpackage

/* File: hdl/ecu_counter_unit.sv */
// eight-bit timer counter unit with avalon-mm register slave
//
// Functional notes
// - count of zero means bottom
// - count of all ones means max
// - top is all ones or compare a
// - tick from io clock by default
// - async select takes tick from oscillator pin
// - count step is exactly one, per direction
// - clear forces counter to zero
// - top indication when sequence top reached
// - bottom indication when counter is zero
// - each tick clears, increments or decrements
// - clock select zero stops the counter
// - cpu may access count any time
// - cpu write beats clear or count
// - mode bits split over control a and b
// - overflow flag per mode, raises interrupt
// - normal mode wraps, overflow at zero
// - ctc mode clears on compare a match
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module ecu_counter_unit
  import ecu_pkg::*;
(
  input  wire logic              clock,           // 40 MHz system clock
  input  wire logic              rstn,            // async reset, low
  input  wire logic [ECU_AW-1:0] avs_address,     // byte address
  input  wire logic              avs_read,        // read request
  input  wire logic              avs_write,       // write request
  input  wire logic [31:0]       avs_writedata,   // write data
  input  wire logic [3:0]        avs_byteenable,  // byte lanes
  output logic      [31:0]       avs_readdata,    // read data
  output logic                   avs_waitrequest, // stall request
  input  wire logic              osc_in_pin,      // crystal clock in
  output logic                   irq,             // level interrupt
  output logic                   top_ind,         // count at top
  output logic                   bottom_ind       // count at zero
);

  // ==========================================================
  // registers
  logic [1:0] ctrl_a_r;      // waveform mode bits 1:0
  logic [3:0] ctrl_b_r;      // mode bit 2 and clock select
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] cmp_a_r;
  logic       async_sel_r;
  logic [1:0] int_stat_r;
  logic [1:0] int_stat_nxt;
  logic [1:0] int_mask_r;
  ecu_dir_e   dir_r;
  ecu_dir_e   dir_nxt;
  logic       wait_r;
  logic [31:0] rdata_r;
  logic       irq_r;
  logic       top_r;
  logic       bottom_r;
  logic       osc_s1_r;
  logic       osc_s2_r;
  logic       osc_s3_r;

  // ==========================================================
  // bus decode
  logic       wr_go;
  logic [7:0] wdata8;
  logic       cnt_wr;
  logic [2:0] mode_w;
  logic [2:0] cs_w;
  logic [7:0] top_val;
  logic       at_top;
  logic       at_bottom;
  logic       at_max;
  logic       osc_edge;
  logic       tick;
  logic       ovf_ev;
  logic       cmpa_ev;
  logic       irq_any;
  logic       dual_w;
  logic       fast_w;

  // a write lands only at the edge that ends its wait; only lane 0
  // carries data since no register is wider than eight bits
  assign wr_go  = avs_write & ~wait_r & avs_byteenable[0];
  assign wdata8 = avs_writedata[7:0];
  assign cnt_wr = wr_go & (avs_address == OFF_COUNT);

  // mode is assembled from both control registers
  assign mode_w = {ctrl_b_r[CTRL_B_WGM2_BIT], ctrl_a_r};
  assign cs_w   = ctrl_b_r[2:0];

  // reference points
  assign top_val   = ecu_top_of(mode_w, cmp_a_r);
  assign at_top    = (count_r == top_val);
  assign at_bottom = (count_r == BOTTOM_VAL);
  assign at_max    = (count_r == MAX_VAL);

  // ==========================================================
  // tick source
  // oscillator pin is foreign to this clock: two flops, then edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      osc_s1_r <= osc_in_pin;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  assign osc_edge = osc_s2_r & ~osc_s3_r;

  // prescaling lives elsewhere; any nonzero select ticks here
  always_comb begin
    if (cs_w == CS_STOP) begin
      tick = 1'b0;
    end else if (async_sel_r) begin
      tick = osc_edge;
    end else begin
      tick = 1'b1;
    end
  end

  // ==========================================================
  // counting sequence
  always_comb begin
    count_nxt = count_r;
    dir_nxt   = dir_r;
    ovf_ev    = 1'b0;
    cmpa_ev   = 1'b0;
    if (cnt_wr) begin
      count_nxt = wdata8;
    end else if (tick) begin
      cmpa_ev = (count_r == cmp_a_r);
      case (mode_w)
        WGM_PC_MAX, WGM_PC_CMP: begin
          // dual slope turns at top and at bottom
          case (dir_r)
            ECU_UP: begin
              if (at_top) begin
                dir_nxt   = ECU_DOWN;
                count_nxt = count_r - 8'h01;
              end else begin
                count_nxt = count_r + 8'h01;
              end
            end
            ECU_DOWN: begin
              if (at_bottom) begin
                dir_nxt   = ECU_UP;
                count_nxt = count_r + 8'h01;
                ovf_ev    = 1'b1;
              end else begin
                count_nxt = count_r - 8'h01;
              end
            end
            default: begin
              dir_nxt = ECU_UP;
            end
          endcase
        end
        WGM_CTC, WGM_FAST_MAX, WGM_FAST_CMP: begin
          dir_nxt = ECU_UP;
          if (at_top) begin
            count_nxt = BOTTOM_VAL;
            ovf_ev    = (mode_w != WGM_CTC) | at_max;
          end else begin
            // a missed compare still wraps past max
            count_nxt = count_r + 8'h01;
            ovf_ev    = at_max;
          end
        end
        default: begin
          // normal mode and the unused codes: plain up count
          dir_nxt   = ECU_UP;
          count_nxt = count_r + 8'h01;
          ovf_ev    = at_max;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_r <= COUNT_RST;
      dir_r   <= ECU_UP;
    end else begin
      count_r <= count_nxt;
      dir_r   <= dir_nxt;
    end
  end

  // indications lag the count by one edge so they leave a flop
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      top_r    <= 1'b0;
      bottom_r <= 1'b0;
    end else begin
      top_r    <= at_top;
      bottom_r <= at_bottom;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_a_r    <= CTRL_A_RST;
      ctrl_b_r    <= CTRL_B_RST;
      cmp_a_r     <= CMP_RST;
      async_sel_r <= 1'b0;
      int_mask_r  <= INT_RST;
    end else if (wr_go) begin
      case (avs_address)
        OFF_CTRL_A:   ctrl_a_r    <= wdata8[1:0];
        OFF_CTRL_B:   ctrl_b_r    <= wdata8[3:0];
        OFF_CMP_A:    cmp_a_r     <= wdata8;
        OFF_ASYNC:    async_sel_r <= wdata8[ASYNC_SEL_BIT];
        OFF_INT_MASK: int_mask_r  <= wdata8[1:0];
        default:      ;
      endcase
    end
  end

  // ==========================================================
  // interrupt status, write one to clear; a new event wins
  always_comb begin
    int_stat_nxt = int_stat_r;
    if (wr_go && (avs_address == OFF_INT_STAT)) begin
      int_stat_nxt = int_stat_r & ~wdata8[1:0];
    end
    int_stat_nxt[INT_OVF_BIT]  = int_stat_nxt[INT_OVF_BIT] | ovf_ev;
    int_stat_nxt[INT_CMPA_BIT] = int_stat_nxt[INT_CMPA_BIT] | cmpa_ev;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      int_stat_r <= INT_RST;
      irq_r      <= 1'b0;
    end else begin
      int_stat_r <= int_stat_nxt;
      irq_r      <= |(int_stat_r & int_mask_r);
    end
  end

  // ==========================================================
  // bus handshake: one wait cycle per access
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~((avs_read | avs_write) & wait_r);
    end
  end

  // read data captured in the wait cycle; unmapped reads give zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read && wait_r) begin
      case (avs_address)
        OFF_CTRL_A:   rdata_r <= {30'h0, ctrl_a_r};
        OFF_CTRL_B:   rdata_r <= {28'h0, ctrl_b_r};
        OFF_COUNT:    rdata_r <= {24'h0, count_r};
        OFF_CMP_A:    rdata_r <= {24'h0, cmp_a_r};
        OFF_ASYNC:    rdata_r <= {31'h0, async_sel_r};
        OFF_INT_STAT: rdata_r <= {30'h0, int_stat_r};
        OFF_INT_MASK: rdata_r <= {30'h0, int_mask_r};
        default:      rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign irq             = irq_r;
  assign top_ind         = top_r;
  assign bottom_ind      = bottom_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // helper terms used by the checks only
  assign irq_any = |(int_stat_r & int_mask_r);
  assign dual_w  = (mode_w == WGM_PC_MAX) || (mode_w == WGM_PC_CMP);
  assign fast_w  = (mode_w == WGM_FAST_MAX) || (mode_w == WGM_FAST_CMP);

  sequence s_run_normal;
    tick && !cnt_wr && (mode_w == WGM_NORMAL);
  endsequence

  // one normal mode step taken from the all ones value
  sequence s_wrap_normal;
    tick && !cnt_wr && (mode_w == WGM_NORMAL) && at_max;
  endsequence

  sequence s_ovf_armed;
    ovf_ev && int_mask_r[INT_OVF_BIT] ##1 int_mask_r[INT_OVF_BIT];
  endsequence

  // dual slope rising into its top turns round
  sequence s_dual_turn_top;
    tick && !cnt_wr && dual_w && (dir_r == ECU_UP) && at_top;
  endsequence

  // dual slope falling above bottom keeps falling
  sequence s_dual_fall;
    tick && !cnt_wr && dual_w && (dir_r == ECU_DOWN) && !at_bottom;
  endsequence

  // single slope at its top clears
  sequence s_fast_top;
    tick && !cnt_wr && fast_w && at_top;
  endsequence

  // first edge after reset still shows the reset value of the flop
  AST_BOTTOM_IND: assert property (
    $past(rstn) |-> bottom_r == $past(at_bottom))
    else $error("bottom indication wrong");

  AST_MAX_WRAP: assert property (
    s_wrap_normal |=> count_r == BOTTOM_VAL)
    else $error("normal mode did not wrap at max");

  AST_TOP_IND: assert property (
    $past(rstn) |-> top_r == $past(at_top))
    else $error("top indication wrong");

  AST_STEP_ONE: assert property (
    s_run_normal |=> count_r == $past(count_r) + 8'h01)
    else $error("count did not step by one");

  AST_STOPPED: assert property (
    (cs_w == CS_STOP) && !cnt_wr |=> $stable(count_r))
    else $error("counter moved while stopped");

  AST_WRITE_WINS: assert property (
    cnt_wr |=> count_r == $past(wdata8))
    else $error("cpu write to count lost");

  AST_CTC_CLEAR: assert property (
    tick && !cnt_wr && (mode_w == WGM_CTC) && (count_r == cmp_a_r)
    |=> count_r == BOTTOM_VAL)
    else $error("ctc did not clear on compare");

  AST_NORMAL_OVF: assert property (
    s_wrap_normal |=> int_stat_r[INT_OVF_BIT])
    else $error("overflow flag not set at wrap");

  AST_OVF_IRQ: assert property (
    s_ovf_armed |=> irq_r)
    else $error("unmasked overflow gave no interrupt");

  AST_ASYNC_TICK: assert property (
    async_sel_r && !osc_edge |-> !tick)
    else $error("tick without oscillator edge");

  AST_SYNC_TICK: assert property (
    !async_sel_r && (cs_w != CS_STOP) |-> tick)
    else $error("io clock tick missing");

  AST_DUAL_TURN: assert property (
    s_dual_turn_top
    |=> (dir_r == ECU_DOWN) && (count_r == $past(count_r) - 8'h01))
    else $error("dual slope did not turn at top");

  AST_DUAL_FALL: assert property (
    s_dual_fall |=> count_r == $past(count_r) - 8'h01)
    else $error("dual slope did not step down");

  AST_FAST_CLEAR: assert property (
    s_fast_top |=> (count_r == BOTTOM_VAL) && int_stat_r[INT_OVF_BIT])
    else $error("single slope did not clear at top");

  AST_CMPA_FLAG: assert property (
    cmpa_ev |=> int_stat_r[INT_CMPA_BIT])
    else $error("compare match flag not set");

  AST_WAIT_ONE: assert property (
    (avs_read || avs_write) && wait_r |=> !wait_r ##1 wait_r)
    else $error("access did not take one wait cycle");

  AST_IRQ_LEVEL: assert property (
    $past(rstn) |-> irq_r == $past(irq_any))
    else $error("interrupt level wrong");

endmodule // ecu_counter_unit

/* File: bench/tb_top.sv */
// self-checking bench for the eight-bit counter unit
`timescale 1ns/1ps

module tb_top;
  import ecu_pkg::*;
  // ==========================================================
  // design signals and score keeping
  logic              clock;
  logic              rstn;
  logic [ECU_AW-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              osc_in_pin;
  logic              irq;
  logic              top_ind;
  logic              bottom_ind;
  int                mismatches;
  int                checks;
  int                cycles;
  logic [31:0]       rd;
  logic [7:0]        tp;
  logic [2:0]        md [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
  logic [7:0]        cm [6] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h05, 8'h06};
  logic [7:0]        st [6] = '{8'hFE, 8'hFF, 8'h02, 8'hFE, 8'h05, 8'h05};
  logic [7:0]        e1 [6] = '{8'hFF, 8'hFE, 8'h03, 8'hFF, 8'h04, 8'h06};
  logic [7:0]        e2 [6] = '{8'h00, 8'hFD, 8'h00, 8'h00, 8'h03, 8'h00};
  logic [1:0]        sf [6] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h2, 2'h3};

  ecu_counter_unit uut (
    .clock(clock), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .osc_in_pin(osc_in_pin), .irq(irq), .top_ind(top_ind),
    .bottom_ind(bottom_ind)
  );

  // ==========================================================
  // clock and hang guard, ceiling well above the planned run
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial cycles = 0;
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  // ==========================================================
  // comparisons and closing report
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic chk_bit(input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // avalon cycle: hold until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, 4'hF);
  endtask
  task automatic rdv(input logic [4:0] a, input logic [7:0] exp);
    bus(1'b0, a, 32'h0, 4'h0);
    chk({24'h0, exp}, rd);
  endtask
  // one oscillator period, both phases longer than two clocks
  task automatic pulse();
    @(posedge clock);
    osc_in_pin <= 1'b1;
    repeat (4) @(posedge clock);
    osc_in_pin <= 1'b0;
    repeat (6) @(posedge clock);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    mismatches = 0;
    checks = 0;
    rstn = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    osc_in_pin = 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    chk_bit(1'b1, bottom_ind);
    chk_bit(1'b0, top_ind);
    for (int i = 0; i < 7; i++) rdv(5'(i * 4), 8'h00);
    rdv(5'h1C, 8'h00);
    $display("test reset done");
    // internal source: a running count is overwritten by the cpu
    wr(OFF_CTRL_B, 8'h01);
    wr(OFF_COUNT, 8'h40);
    wr(OFF_CTRL_B, 8'h00);
    bus(1'b0, OFF_COUNT, 32'h0, 4'h0);
    chk_bit(1'b1, rd > 32'h40 && rd < 32'h49);
    tp = rd[7:0];
    repeat (20) @(posedge clock);
    rdv(OFF_COUNT, tp);
    bus(1'b1, OFF_COUNT, 32'h99, 4'h0);
    rdv(OFF_COUNT, tp);
    $display("test internal done");
    // oscillator source: one step per pin period, per mode
    wr(OFF_ASYNC, 8'h01);
    rdv(OFF_ASYNC, 8'h01);
    // overflow unmasked so the interrupt follows every mode
    wr(OFF_INT_MASK, 8'h01);
    for (int i = 0; i < 6; i++) begin
      tp = (md[i] == 3'h2 || md[i] == 3'h5 || md[i] == 3'h7)
           ? cm[i] : 8'hFF;
      wr(OFF_CTRL_B, 8'h00);
      wr(OFF_CTRL_A, {6'h0, md[i][1:0]});
      wr(OFF_CMP_A, cm[i]);
      wr(OFF_COUNT, st[i]);
      wr(OFF_INT_STAT, 8'h03);
      wr(OFF_CTRL_B, {4'h0, md[i][2], 3'h1});
      pulse();
      rdv(OFF_COUNT, e1[i]);
      chk_bit(e1[i] == tp, top_ind);
      pulse();
      rdv(OFF_COUNT, e2[i]);
      chk_bit(e2[i] == 8'h00, bottom_ind);
      chk_bit(e2[i] == tp, top_ind);
      rdv(OFF_INT_STAT, {6'h0, sf[i]});
      chk_bit(sf[i][0], irq);
      $display("test mode %0d done", md[i]);
    end
    // interrupt: status left at 3 by the last mode
    wr(OFF_INT_MASK, 8'h01);
    repeat (3) @(posedge clock);
    chk_bit(1'b1, irq);
    wr(OFF_INT_MASK, 8'h00);
    repeat (3) @(posedge clock);
    chk_bit(1'b0, irq);
    wr(OFF_INT_MASK, 8'h01);
    wr(OFF_INT_STAT, 8'h01);
    repeat (3) @(posedge clock);
    chk_bit(1'b0, irq);
    rdv(OFF_INT_STAT, 8'h02);
    wr(OFF_INT_MASK, 8'h02);
    repeat (3) @(posedge clock);
    chk_bit(1'b1, irq);
    $display("test interrupt done");
    results();
  end
endmodule // tb_top
